/* page_walk_cfg.svh */
// Summary of operation
// - small pages: linear bits 22..31 pick the directory entry, giving a table base
// - small pages: linear bits 12..21 pick the table entry, giving the page base
// - small pages: linear bits 0..11 pass through as the page offset
// - large page only when large_page_enable and the entry size bit are both set
// - large pages: bits 22..31 pick a directory entry giving the page base directly
// - large pages: linear bits 0..21 pass through as the page offset
// - with large_page_enable clear every directory entry points to a table
// - with large_page_enable set both entry kinds mix in one directory
// - large and small translations live in two separate lookaside buffers
// - every walk starts at the directory base register
// - directory base loads by explicit load or by task switch
// - directory base has no present bit; the directory is assumed resident
// - a clear present bit raises a page fault instead of translating
// - accessed bit 5 is set on first use and never cleared here
// - dirty bit 6 of a page entry is set on first write, never cleared
// - entry base fields give the top 20 physical bits, 4 KB aligned; large page entries give only the top 10, 4 MB aligned
`ifndef PAGE_WALK_CFG_SVH
`define PAGE_WALK_CFG_SVH
`define PW_DIR_IDX_HI   31
`define PW_DIR_IDX_LO   22
`define PW_TBL_IDX_HI   21
`define PW_TBL_IDX_LO   12
`define PW_SM_OFF_HI    11
`define PW_LG_OFF_HI    21
`define PW_BASE_LO      12
`define PW_LG_BASE_LO   22
`define PW_BIT_PRESENT  0
`define PW_BIT_ACCESSED 5
`define PW_BIT_DIRTY    6
`define PW_BIT_SIZE     7
`define PW_ENTRY_PAD    2'h0
`define PW_SM_IDX_W     4
`define PW_SM_TAG_W     16
`define PW_LG_IDX_W     2
`define PW_LG_TAG_W     8
`define PW_SM_DATA_W    20
`define PW_LG_DATA_W    10
`define PW_DIR_RESET    32'h0000_0000
`endif

/* page_walk_pkg.sv */
package page_walk_pkg;
  // walk sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOOKUP,
    ST_DIR_RD,
    ST_DIR_WR,
    ST_TBL_RD,
    ST_TBL_WR
  } walk_state_e;
endpackage

/* tlb_bank.sv */
`timescale 1ns/100ps
// direct-mapped translation buffer; one instance per page size
module tlb_bank #(
  parameter int IDX_W  = 4,
  parameter int TAG_W  = 16,
  parameter int DATA_W = 20
) (
  // clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_sys_rst,
  // lookup
  input  wire logic [IDX_W-1:0]  i_look_idx,
  input  wire logic [TAG_W-1:0]  i_look_tag,
  output logic                   o_hit,
  output logic [DATA_W-1:0]      o_data,
  output logic                   o_dirty,
  // fill and flush
  input  wire logic              i_fill,
  input  wire logic [IDX_W-1:0]  i_fill_idx,
  input  wire logic [TAG_W-1:0]  i_fill_tag,
  input  wire logic [DATA_W-1:0] i_fill_data,
  input  wire logic              i_fill_dirty,
  input  wire logic              i_flush
);
  localparam int DEPTH = 1 << IDX_W;

  logic [DEPTH-1:0]  valid_q;
  logic [TAG_W-1:0]  tag_q   [DEPTH];
  logic [DATA_W-1:0] data_q  [DEPTH];
  logic [DEPTH-1:0]  dirty_q;

  // valid bits; flush wins so a stale fill cannot survive a base change
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      valid_q <= '0;
    else if (i_flush)
      valid_q <= '0;
    else if (i_fill)
      valid_q[i_fill_idx] <= 1'b1;
  end

  // payload needs no reset, valid guards it
  always_ff @(posedge i_mclk)
  begin
    if (i_fill)
    begin
      tag_q[i_fill_idx]   <= i_fill_tag;
      data_q[i_fill_idx]  <= i_fill_data;
      dirty_q[i_fill_idx] <= i_fill_dirty;
    end
  end

  // combinational lookup
  assign o_hit   = valid_q[i_look_idx] && (tag_q[i_look_idx] == i_look_tag);
  assign o_data  = data_q[i_look_idx];
  assign o_dirty = dirty_q[i_look_idx];
endmodule

/* page_walker.sv */
`timescale 1ns/100ps
`include "page_walk_cfg.svh"
// two-level linear to physical translation with split lookaside buffers
module page_walker (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  // control from the core
  input  wire logic        i_large_page_enable,
  input  wire logic        i_dir_base_load,
  input  wire logic [31:0] i_dir_base_value,
  input  wire logic        i_task_switch_load,
  input  wire logic [31:0] i_task_dir_base,
  input  wire logic        i_tlb_flush,
  output logic [31:0]      o_dir_base,
  // translation request
  input  wire logic        i_req_valid,
  input  wire logic [31:0] i_req_lin_addr,
  input  wire logic        i_req_write,
  output logic             o_req_ready,
  // translation answer
  output logic             o_resp_valid,
  output logic [31:0]      o_resp_phys_addr,
  output logic             o_resp_large,
  output logic             o_page_fault_exception,
  // table memory
  output logic             o_mem_rd,
  output logic             o_mem_wr,
  output logic [31:0]      o_mem_addr,
  output logic [31:0]      o_mem_wdata,
  input  wire logic        i_mem_ack,
  input  wire logic [31:0] i_mem_rdata
);
  // ==========================================================
  // state
  // ==========================================================
  page_walk_pkg::walk_state_e state_q, state_d;
  logic [31:0] dir_base_q;
  logic [31:0] lin_q;
  logic        write_q;
  logic [31:0] pde_q;
  logic [31:0] pte_q;
  logic        sm_hit, lg_hit, sm_dirty, lg_dirty;
  logic [`PW_SM_DATA_W-1:0] sm_data;
  logic [`PW_LG_DATA_W-1:0] lg_data;
  logic        sm_fill, lg_fill, flush;
  logic        pde_large, pde_need_wr, pte_need_wr;
  logic [31:0] pde_upd, pte_upd;
  logic        req_take;

  assign req_take = (state_q == page_walk_pkg::ST_IDLE) && i_req_valid;
  // a new directory invalidates every cached translation
  assign flush    = i_tlb_flush || i_dir_base_load || i_task_switch_load;

  // ==========================================================
  // directory base register
  // ==========================================================
  // explicit load wins over a task switch in the same cycle; no present bit kept
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      dir_base_q <= `PW_DIR_RESET;
    else if (i_dir_base_load)
      dir_base_q <= i_dir_base_value;
    else if (i_task_switch_load)
      dir_base_q <= i_task_dir_base;
  end

  // ==========================================================
  // lookaside buffers
  // ==========================================================
  // separate banks keep kernel large pages from evicting small entries
  tlb_bank #(
    .IDX_W  (`PW_SM_IDX_W),
    .TAG_W  (`PW_SM_TAG_W),
    .DATA_W (`PW_SM_DATA_W)
  ) u_small_tlb (
    .i_mclk       (i_mclk),
    .i_sys_rst    (i_sys_rst),
    .i_look_idx   (lin_q[`PW_BASE_LO +: `PW_SM_IDX_W]),
    .i_look_tag   (lin_q[31 -: `PW_SM_TAG_W]),
    .o_hit        (sm_hit),
    .o_data       (sm_data),
    .o_dirty      (sm_dirty),
    .i_fill       (sm_fill),
    .i_fill_idx   (lin_q[`PW_BASE_LO +: `PW_SM_IDX_W]),
    .i_fill_tag   (lin_q[31 -: `PW_SM_TAG_W]),
    .i_fill_data  (pte_upd[31:`PW_BASE_LO]),
    .i_fill_dirty (pte_upd[`PW_BIT_DIRTY]),
    .i_flush      (flush)
  );

  tlb_bank #(
    .IDX_W  (`PW_LG_IDX_W),
    .TAG_W  (`PW_LG_TAG_W),
    .DATA_W (`PW_LG_DATA_W)
  ) u_large_tlb (
    .i_mclk       (i_mclk),
    .i_sys_rst    (i_sys_rst),
    .i_look_idx   (lin_q[`PW_LG_BASE_LO +: `PW_LG_IDX_W]),
    .i_look_tag   (lin_q[31 -: `PW_LG_TAG_W]),
    .o_hit        (lg_hit),
    .o_data       (lg_data),
    .o_dirty      (lg_dirty),
    .i_fill       (lg_fill),
    .i_fill_idx   (lin_q[`PW_LG_BASE_LO +: `PW_LG_IDX_W]),
    .i_fill_tag   (lin_q[31 -: `PW_LG_TAG_W]),
    .i_fill_data  (pde_upd[31:`PW_LG_BASE_LO]),
    .i_fill_dirty (pde_upd[`PW_BIT_DIRTY]),
    .i_flush      (flush)
  );

  // ==========================================================
  // entry decode
  // ==========================================================
  // size bit counts only with large pages enabled; otherwise every entry is a table
  assign pde_large = i_large_page_enable && i_mem_rdata[`PW_BIT_SIZE];

  // accessed always; directory dirty only on a write through a large page entry, table dirty on any write
  always_comb
  begin
    pde_upd = i_mem_rdata;
    pde_upd[`PW_BIT_ACCESSED] = 1'b1;
    if (pde_large && write_q)
      pde_upd[`PW_BIT_DIRTY] = 1'b1;
    pte_upd = i_mem_rdata;
    pte_upd[`PW_BIT_ACCESSED] = 1'b1;
    if (write_q)
      pte_upd[`PW_BIT_DIRTY] = 1'b1;
  end

  // write back only when a sticky bit actually changes
  assign pde_need_wr = (pde_upd != i_mem_rdata);
  assign pte_need_wr = (pte_upd != i_mem_rdata);

  // fills happen when the walked entry is read and present
  assign lg_fill = (state_q == page_walk_pkg::ST_DIR_RD) && i_mem_ack
                   && i_mem_rdata[`PW_BIT_PRESENT] && pde_large;
  assign sm_fill = (state_q == page_walk_pkg::ST_TBL_RD) && i_mem_ack
                   && i_mem_rdata[`PW_BIT_PRESENT];

  // ==========================================================
  // walk sequencer
  // ==========================================================
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      page_walk_pkg::ST_IDLE:
        if (i_req_valid)
          state_d = page_walk_pkg::ST_LOOKUP;
      page_walk_pkg::ST_LOOKUP:
        // a clean cached page still walks on a write so dirty gets set
        if ((lg_hit && (!write_q || lg_dirty)) || (sm_hit && (!write_q || sm_dirty)))
          state_d = page_walk_pkg::ST_IDLE;
        else
          state_d = page_walk_pkg::ST_DIR_RD;
      page_walk_pkg::ST_DIR_RD:
        if (i_mem_ack)
        begin
          if (!i_mem_rdata[`PW_BIT_PRESENT])
            state_d = page_walk_pkg::ST_IDLE;
          else if (pde_need_wr)
            state_d = page_walk_pkg::ST_DIR_WR;
          else if (pde_large)
            state_d = page_walk_pkg::ST_IDLE;
          else
            state_d = page_walk_pkg::ST_TBL_RD;
        end
      page_walk_pkg::ST_DIR_WR:
        if (i_mem_ack)
          state_d = pde_q[`PW_BIT_SIZE] && i_large_page_enable ?
                    page_walk_pkg::ST_IDLE : page_walk_pkg::ST_TBL_RD;
      page_walk_pkg::ST_TBL_RD:
        if (i_mem_ack)
        begin
          if (i_mem_rdata[`PW_BIT_PRESENT] && pte_need_wr)
            state_d = page_walk_pkg::ST_TBL_WR;
          else
            state_d = page_walk_pkg::ST_IDLE;
        end
      page_walk_pkg::ST_TBL_WR:
        if (i_mem_ack)
          state_d = page_walk_pkg::ST_IDLE;
      default:
        state_d = page_walk_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      state_q <= page_walk_pkg::ST_IDLE;
    else
      state_q <= state_d;
  end

  // request capture
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      lin_q   <= 32'h0000_0000;
      write_q <= 1'b0;
    end
    else if (req_take)
    begin
      lin_q   <= i_req_lin_addr;
      write_q <= i_req_write;
    end
  end

  // entry holding registers keep the updated image for the write back
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      pde_q <= 32'h0000_0000;
      pte_q <= 32'h0000_0000;
    end
    else if (i_mem_ack && state_q == page_walk_pkg::ST_DIR_RD)
      pde_q <= pde_upd;
    else if (i_mem_ack && state_q == page_walk_pkg::ST_TBL_RD)
      pte_q <= pte_upd;
  end

  // ==========================================================
  // memory port
  // ==========================================================
  // strobes held until ack; table address taken from the directory read data in the ack cycle, else from pde_q
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_mem_rd    <= 1'b0;
      o_mem_wr    <= 1'b0;
      o_mem_addr  <= 32'h0000_0000;
      o_mem_wdata <= 32'h0000_0000;
    end
    else
    begin
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      case (state_d)
        page_walk_pkg::ST_DIR_RD:
        begin
          o_mem_rd   <= 1'b1;
          // base register assumed to name a resident directory
          o_mem_addr <= {dir_base_q[31:`PW_BASE_LO], lin_q[`PW_DIR_IDX_HI:`PW_DIR_IDX_LO],
                         `PW_ENTRY_PAD};
        end
        page_walk_pkg::ST_DIR_WR:
        begin
          o_mem_wr    <= 1'b1;
          o_mem_wdata <= (state_q == page_walk_pkg::ST_DIR_RD) ? pde_upd : pde_q;
        end
        page_walk_pkg::ST_TBL_RD:
        begin
          o_mem_rd   <= 1'b1;
          o_mem_addr <= {(state_q == page_walk_pkg::ST_DIR_RD) ? pde_upd[31:`PW_BASE_LO]
                                                               : pde_q[31:`PW_BASE_LO],
                         lin_q[`PW_TBL_IDX_HI:`PW_TBL_IDX_LO], `PW_ENTRY_PAD};
        end
        page_walk_pkg::ST_TBL_WR:
        begin
          o_mem_wr    <= 1'b1;
          // hold the captured image while waiting, the read data line is not kept
          o_mem_wdata <= (state_q == page_walk_pkg::ST_TBL_RD) ? pte_upd : pte_q;
        end
        default:
        begin
          o_mem_rd <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // answer to the core
  // ==========================================================
  // one-cycle answer whenever the sequencer returns to idle from a busy state
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_resp_valid           <= 1'b0;
      o_resp_phys_addr       <= 32'h0000_0000;
      o_resp_large           <= 1'b0;
      o_page_fault_exception <= 1'b0;
    end
    else
    begin
      o_resp_valid           <= (state_q != page_walk_pkg::ST_IDLE)
                                && (state_d == page_walk_pkg::ST_IDLE);
      o_page_fault_exception <= 1'b0;
      o_resp_large           <= 1'b0;
      case (state_q)
        page_walk_pkg::ST_LOOKUP:
          if (lg_hit && (!write_q || lg_dirty))
          begin
            o_resp_phys_addr <= {lg_data, lin_q[`PW_LG_OFF_HI:0]};
            o_resp_large     <= 1'b1;
          end
          else
            o_resp_phys_addr <= {sm_data, lin_q[`PW_SM_OFF_HI:0]};
        page_walk_pkg::ST_DIR_RD:
        begin
          o_page_fault_exception <= i_mem_ack && !i_mem_rdata[`PW_BIT_PRESENT];
          o_resp_large           <= pde_large;
          o_resp_phys_addr       <= {i_mem_rdata[31:`PW_LG_BASE_LO], lin_q[`PW_LG_OFF_HI:0]};
        end
        page_walk_pkg::ST_DIR_WR:
        begin
          o_resp_large     <= 1'b1;
          o_resp_phys_addr <= {pde_q[31:`PW_LG_BASE_LO], lin_q[`PW_LG_OFF_HI:0]};
        end
        page_walk_pkg::ST_TBL_RD:
        begin
          o_page_fault_exception <= i_mem_ack && !i_mem_rdata[`PW_BIT_PRESENT];
          o_resp_phys_addr       <= {i_mem_rdata[31:`PW_BASE_LO], lin_q[`PW_SM_OFF_HI:0]};
        end
        page_walk_pkg::ST_TBL_WR:
          o_resp_phys_addr <= {pte_q[31:`PW_BASE_LO], lin_q[`PW_SM_OFF_HI:0]};
        default:
          o_resp_phys_addr <= o_resp_phys_addr;
      endcase
    end
  end

  // ready registered from the next state so it is a flop output
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_req_ready <= 1'b0;
    else
      o_req_ready <= (state_d == page_walk_pkg::ST_IDLE);
  end

  // mirror of the directory base for status
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_dir_base <= `PW_DIR_RESET;
    else
      o_dir_base <= dir_base_q;
  end
endmodule

/* page_walker_assertions.sv */
`timescale 1ns/100ps
// ==========
// port-level checker for the walker
module page_walker_checker (
  // clock and reset
  input wire logic        i_mclk,
  input wire logic        i_sys_rst,
  // control
  input wire logic        i_dir_base_load,
  input wire logic [31:0] i_dir_base_value,
  input wire logic        i_task_switch_load,
  input wire logic [31:0] i_task_dir_base,
  input wire logic [31:0] o_dir_base,
  // request and answer
  input wire logic        i_req_valid,
  input wire logic        o_req_ready,
  input wire logic        o_resp_valid,
  input wire logic        o_page_fault_exception,
  // table memory
  input wire logic        o_mem_rd,
  input wire logic        o_mem_wr,
  input wire logic [31:0] o_mem_addr,
  input wire logic [31:0] o_mem_wdata,
  input wire logic        i_mem_ack
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  base_load_a: assert property (i_dir_base_load |-> ##2 o_dir_base == $past(i_dir_base_value, 2))
    else $error("directory base not loaded by explicit load");
  task_load_a: assert property (i_task_switch_load && !i_dir_base_load |-> ##2 o_dir_base == $past(i_task_dir_base, 2))
    else $error("directory base not loaded by task switch");
  take_busy_a: assert property (o_req_ready && i_req_valid |=> !o_req_ready)
    else $error("walker still ready after taking a request");
  resp_gap_a: assert property (o_resp_valid |-> o_req_ready && !$past(o_req_ready))
    else $error("answer not preceded by a busy cycle");
  idle_quiet_a: assert property (o_req_ready |-> !o_mem_rd && !o_mem_wr)
    else $error("table memory accessed while idle");
  strobe_hold_a: assert property ((o_mem_rd || o_mem_wr) && !i_mem_ack |=>
    $stable(o_mem_rd) && $stable(o_mem_wr) && $stable(o_mem_addr) && $stable(o_mem_wdata))
    else $error("memory request changed before acknowledge");
  entry_align_a: assert property (o_mem_rd || o_mem_wr |-> o_mem_addr[1:0] == 2'h0)
    else $error("entry address not word aligned");
  wb_accessed_a: assert property (o_mem_wr |-> o_mem_wdata[5])
    else $error("entry written back without accessed bit");
  fault_resp_a: assert property (o_page_fault_exception |-> o_resp_valid)
    else $error("page fault outside an answer");
endmodule

bind page_walker page_walker_checker chk (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
  .i_dir_base_load(i_dir_base_load), .i_dir_base_value(i_dir_base_value),
  .i_task_switch_load(i_task_switch_load), .i_task_dir_base(i_task_dir_base), .o_dir_base(o_dir_base),
  .i_req_valid(i_req_valid), .o_req_ready(o_req_ready), .o_resp_valid(o_resp_valid),
  .o_page_fault_exception(o_page_fault_exception), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
  .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .i_mem_ack(i_mem_ack));

/* page_mem_model.sv */
`timescale 1ns/100ps
// ==========
// table memory: sparse words, untouched words follow an address pattern
module page_mem_model (
  // clock
  input wire logic         i_mclk,
  // access from the walker
  input wire logic         i_mem_rd,
  input wire logic         i_mem_wr,
  input wire logic [31:0]  i_mem_addr,
  input wire logic [31:0]  i_mem_wdata,
  output logic             o_mem_ack,
  output logic [31:0]      o_mem_rdata
);
  int          lat  = 0;
  int          cnt  = 0;
  int          acks = 0;
  logic [31:0] words [logic [31:0]];

  // pattern gives mixed size bits and about one absent entry in 32
  // four directory entries share each table; the walker sets their flags alike, so no deadlock
  function automatic logic [31:0] peek(input logic [31:0] a);
    if (words.exists(a))
      return words[a];
    return {a[23:4], 4'h0, a[3], 6'h00, a[6:2] != 5'h07};
  endfunction

  initial
  begin
    o_mem_ack   = 1'b0;
    o_mem_rdata = 32'h0;
  end

  // every address answers, the directory is always resident
  always @(posedge i_mclk)
  begin
    if ((i_mem_rd || i_mem_wr) && !o_mem_ack && cnt >= lat)
    begin
      cnt = 0;
      acks++;
      if (i_mem_wr)
        words[i_mem_addr] = i_mem_wdata;
      o_mem_ack   <= #1 1'b1;
      o_mem_rdata <= #1 i_mem_wr ? ~o_mem_rdata : peek(i_mem_addr);
    end
    else
    begin
      if ((i_mem_rd || i_mem_wr) && !o_mem_ack)
        cnt++;
      // data line is not held once the answer is gone
      o_mem_ack   <= #1 1'b0;
      o_mem_rdata <= #1 ~o_mem_rdata;
    end
  end
endmodule

/* tb_top.sv */
`timescale 1ns/100ps
// ==========
// walker bench: core driver, reference translation, scoreboard
module tb_top;
  logic        i_mclk, i_sys_rst, i_large_page_enable, i_dir_base_load, i_task_switch_load;
  logic        i_tlb_flush, i_req_valid, i_req_write, i_mem_ack;
  logic [31:0] i_dir_base_value, i_task_dir_base, i_req_lin_addr, i_mem_rdata;
  logic        o_req_ready, o_resp_valid, o_resp_large, o_page_fault_exception, o_mem_rd, o_mem_wr;
  logic [31:0] o_dir_base, o_resp_phys_addr, o_mem_addr, o_mem_wdata;
  logic [31:0] base, got_pa, exp_pa, r;
  logic        got_lg, got_pf, exp_lg, exp_pf;
  int          errors, total_checks, took;

  page_walker uut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_large_page_enable(i_large_page_enable),
    .i_dir_base_load(i_dir_base_load), .i_dir_base_value(i_dir_base_value),
    .i_task_switch_load(i_task_switch_load), .i_task_dir_base(i_task_dir_base), .i_tlb_flush(i_tlb_flush),
    .o_dir_base(o_dir_base), .i_req_valid(i_req_valid), .i_req_lin_addr(i_req_lin_addr),
    .i_req_write(i_req_write), .o_req_ready(o_req_ready), .o_resp_valid(o_resp_valid),
    .o_resp_phys_addr(o_resp_phys_addr), .o_resp_large(o_resp_large),
    .o_page_fault_exception(o_page_fault_exception), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
    .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata));
  page_mem_model mem (.i_mclk(i_mclk), .i_mem_rd(o_mem_rd), .i_mem_wr(o_mem_wr), .i_mem_addr(o_mem_addr),
    .i_mem_wdata(o_mem_wdata), .o_mem_ack(i_mem_ack), .o_mem_rdata(i_mem_rdata));

  // 250 MHz
  initial
  begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end

  // ==========
  // shared tasks
  task tick;
    @(posedge i_mclk);
    #1;
  endtask

  task end_of_test;
    if (errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task cmp_word(input logic [31:0] e, input logic [31:0] a);
    total_checks++;
    if (a !== e)
    begin
      errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask

  task cmp_bit(input logic e, input logic a);
    cmp_word({31'h0, e}, {31'h0, a});
  endtask

  // reference walk read straight from the tables
  task ref_tr(input logic [31:0] lin, output logic [31:0] da, ta, de, te);
    da = {base[31:12], lin[31:22], 2'h0};
    de = mem.peek(da);
    ta = {de[31:12], lin[21:12], 2'h0};
    te = mem.peek(ta);
    exp_lg = i_large_page_enable && de[7];
    exp_pf = !de[0] || (!exp_lg && !te[0]);
    exp_pa = exp_lg ? {de[31:22], lin[21:0]} : {te[31:12], lin[11:0]};
  endtask

  // one request; bounded waits for ready and for the answer
  task request(input logic [31:0] lin, input logic wr);
    int n;
    n = 0;
    while (o_req_ready !== 1'b1 && n < 200)
    begin
      tick;
      n++;
    end
    i_req_valid    = 1'b1;
    i_req_lin_addr = lin;
    i_req_write    = wr;
    tick;
    i_req_valid = 1'b0;
    took = 0;
    while (o_resp_valid !== 1'b1 && took < 200)
    begin
      tick;
      took++;
    end
    if (n >= 200 || took >= 200)
    begin
      errors++;
      end_of_test;
    end
    got_pa = o_resp_phys_addr;
    got_lg = o_resp_large;
    got_pf = o_page_fault_exception;
  endtask

  // walk, check entry bits, then repeat for a buffer hit
  task transact(input logic [31:0] lin, input logic wr);
    logic [31:0] da, ta, d0, t0, de, te;
    int          a0;
    ref_tr(lin, da, ta, d0, t0);
    request(lin, wr);
    cmp_bit(exp_pf, got_pf);
    if (!exp_pf)
    begin
      de = mem.peek(da);
      te = mem.peek(ta);
      cmp_word(exp_pa, got_pa);
      cmp_bit(exp_lg, got_lg);
      cmp_bit(1'b1, de[5]);
      cmp_bit(d0[6] | (wr & exp_lg), de[6]);
      if (!exp_lg)
        cmp_word({30'h0, t0[6] | wr, 1'b1}, {30'h0, te[6], te[5]});
      a0 = mem.acks;
      request(lin, wr);
      cmp_bit(1'b1, took == 1);
      cmp_bit(1'b1, mem.acks == a0);
      cmp_word(exp_pa, got_pa);
    end
  endtask

  task set_base(input logic [31:0] b, input logic via_task);
    if (via_task)
    begin
      i_task_switch_load = 1'b1;
      i_task_dir_base    = b;
    end
    else
    begin
      i_dir_base_load  = 1'b1;
      i_dir_base_value = b;
    end
    tick;
    i_task_switch_load = 1'b0;
    i_dir_base_load    = 1'b0;
    tick;
    base = b;
    cmp_word(b, o_dir_base);
  endtask

  // ==========
  // main sequence
  initial
  begin
    {i_large_page_enable, i_dir_base_load, i_task_switch_load, i_tlb_flush, i_req_valid, i_req_write} = 6'h00;
    {i_dir_base_value, i_task_dir_base, i_req_lin_addr, base} = 128'h0;
    i_sys_rst    = 1'b1;
    errors       = 0;
    total_checks = 0;
    r = $urandom(32'hE3928A3A);
    repeat (16) tick;
    i_sys_rst = 1'b0;
    tick;
    cmp_bit(1'b1, o_req_ready);
    cmp_word(32'h0, o_dir_base);
    // tables exist before the first translation is asked for
    set_base(32'h0040_3000, 1'b0);
    transact(32'h01C0_0123, 1'b0);
    for (int i = 0; i < 400; i++)
    begin
      // size-enable changes come with a flush in the same cycle
      if (i % 16 == 0)
      begin
        r = $urandom;
        i_large_page_enable = r[0];
        i_tlb_flush         = 1'b1;
        tick;
        i_tlb_flush = 1'b0;
      end
      if (i % 64 == 63)
      begin
        r = $urandom;
        set_base({r[31:12], 12'h000}, r[0]);
      end
      mem.lat = $urandom % 4;
      r = $urandom;
      transact(r, ^r);
    end
    end_of_test;
  end
endmodule
